/* File: core/flash_fault_protect.sv */
// Summary of operation
// - error status bits 7 to 2 read zero, writes ignored
// - double-bit ECC fault on array read sets double fault flag bit 1
// - read of a busy block sets both fault flags as collision
// - writing 1 clears double fault flag, writing 0 leaves it
// - a true ECC fault sets only one of the two flags
// - fault flags appear one clock after the detecting read
// - single-bit fault sets flag bit 0 only while ignore bit clear
// - single-bit fault returns corrected data
// - writing 1 clears single fault flag, writing 0 leaves it
// - protection writes accepted only if protected size does not shrink
// - protection register reset to 0xff, then loaded from nonvolatile byte at 0xff7c once the fetch completes
// - program or erase on protected area refused, violation flag set
// - block erase refused while any sector is protected
// - operation bit 0: disable bits define unprotected ranges
// - operation bit 1: disable bits define protected ranges
// - high range ends at 0xffff; disable 0 active, 1 removes it
// - high size field writable only while high disable bit set
// - reserved protection bit always reads 1
// - while violation flag set no command is launched
`timescale 1ns/1ps
`default_nettype none

module flash_fault_protect (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	// register port
	input  wire logic [3:0]        bus_addr,
	input  wire logic [7:0]        bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic      [7:0]        bus_rdata,
	// nonvolatile protection byte fetch
	output logic                   nv_rd_req,
	output logic      [15:0]       nv_rd_addr,
	input  wire logic              nv_rd_done,
	input  wire logic [7:0]        nv_rd_data,
	// array read results
	input  wire flash_pkg::rd_evt_t rd_evt,
	output logic      [7:0]        rd_data,
	output logic                   rd_data_valid,
	// program and erase requests
	input  wire flash_pkg::cmd_t   cmd,
	input  wire logic              ctrl_busy,
	output logic                   cmd_accept,
	output logic                   cmd_refused,
	output logic                   prot_ready
);

	flash_pkg::load_st_t state;
	logic [7:0]  config_reg;
	logic [7:0]  prot;
	logic        single_fault_flag;
	logic        double_fault_flag;
	logic        protection_violation_flag;
	logic [7:0]  next_prot;
	logic        prot_wr_ok;
	logic        cmd_blocked;
	logic        wr_config;
	logic        wr_status;
	logic        wr_error;
	logic        wr_prot;
	logic        set_single;
	logic        set_double;
	// load and fault terms
	logic        load_done;
	logic        collision;
	logic        genuine_double;
	logic        genuine_single;
	logic        single_clr;
	logic        double_clr;
	// command terms
	logic        violation_set;
	logic        violation_clr;
	logic        target_protected;
	logic        erase_blocked;
	// protection write terms
	logic [16:0] cur_prot_bytes;
	logic [16:0] new_prot_bytes;
	// bus read terms
	logic [7:0]  next_rdata;

	// size in bytes of a range from its 2-bit field
	function automatic logic [16:0] region_size(input logic [1:0] s);
		region_size = flash_pkg::SIZE_UNIT << s;
	endfunction

	// register select decode
	function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
		reg_hit = (a == off);
	endfunction

	// protection byte with the reserved bit forced high
	function automatic logic [7:0] prot_byte(input logic [7:0] p);
		prot_byte = p | (8'h01 << flash_pkg::PROT_RSVD);
	endfunction

	// address inside the high range, which ends at the top of flash
	function automatic logic high_hit(input logic [7:0] p, input logic [16:0] ax);
		high_hit = !p[flash_pkg::PROT_HDIS]
			&& ((ax + region_size(p[flash_pkg::PROT_HS_LO +: 2])) > flash_pkg::FLASH_TOP);
	endfunction

	// address inside the low range, which starts at the flash base
	function automatic logic low_hit(input logic [7:0] p, input logic [16:0] ax);
		logic [16:0] base;
		base = {1'b0, flash_pkg::FLASH_BASE};
		low_hit = !p[flash_pkg::PROT_LDIS] && (ax >= base)
			&& (ax < (base + region_size(p[flash_pkg::PROT_LS_LO +: 2])));
	endfunction

	// error status byte as software sees it
	function automatic logic [7:0] error_byte(input logic dbl, input logic sgl);
		error_byte = {6'h00, dbl, sgl} & flash_pkg::ERROR_MASK;
	endfunction

	// main status byte as software sees it
	function automatic logic [7:0] status_byte(input logic viol, input logic busy);
		status_byte = ({7'h00, viol} << flash_pkg::STAT_VIOL)
			| ({7'h00, busy} << flash_pkg::STAT_BUSY);
	endfunction

	// number of protected bytes for a protection value
	function automatic logic [16:0] prot_bytes(input logic [7:0] p);
		logic [16:0] h;
		logic [16:0] l;
		h = 17'h00000;
		l = 17'h00000;
		if (!p[flash_pkg::PROT_HDIS]) begin
			h = region_size(p[flash_pkg::PROT_HS_LO +: 2]);
		end
		if (!p[flash_pkg::PROT_LDIS]) begin
			l = region_size(p[flash_pkg::PROT_LS_LO +: 2]);
		end
		if (p[flash_pkg::PROT_OPEN]) begin
			prot_bytes = h + l;
		end else begin
			prot_bytes = flash_pkg::FLASH_BYTES - (h + l);
		end
	endfunction

	// whether one address is protected
	function automatic logic addr_protected(input logic [7:0] p, input logic [15:0] a);
		logic [16:0] ax;
		logic        in_high;
		logic        in_low;
		logic        in_flash;
		ax = {1'b0, a};
		in_flash = (a >= flash_pkg::FLASH_BASE);
		in_high = high_hit(p, ax);
		in_low = low_hit(p, ax);
		if (!in_flash) begin
			addr_protected = 1'b0;
		end else if (p[flash_pkg::PROT_OPEN]) begin
			addr_protected = in_high || in_low;
		end else begin
			addr_protected = !(in_high || in_low);
		end
	endfunction

	// write decodes
	assign wr_config = bus_wr && reg_hit(bus_addr, flash_pkg::OFF_CONFIG);
	assign wr_status = bus_wr && reg_hit(bus_addr, flash_pkg::OFF_STATUS);
	assign wr_error  = bus_wr && reg_hit(bus_addr, flash_pkg::OFF_ERROR);
	assign wr_prot   = bus_wr && reg_hit(bus_addr, flash_pkg::OFF_PROT)
		&& (state == flash_pkg::ST_READY);

	// reset load of protection byte
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= flash_pkg::ST_LOAD;
		end else begin
			case (state)
				flash_pkg::ST_LOAD: begin
					if (nv_rd_done) begin
						state <= flash_pkg::ST_READY;
					end
				end
				flash_pkg::ST_READY: begin
					state <= flash_pkg::ST_READY;
				end
				default: begin
					state <= flash_pkg::ST_LOAD;
				end
			endcase
		end
	end

	assign nv_rd_req  = (state == flash_pkg::ST_LOAD);
	assign load_done  = (state == flash_pkg::ST_LOAD) && nv_rd_done;
	assign nv_rd_addr = flash_pkg::NV_PROT_ADDR;
	assign prot_ready = (state == flash_pkg::ST_READY);

	// candidate protection value from a software write
	always_comb begin
		next_prot = bus_wdata;
		next_prot[flash_pkg::PROT_RSVD] = 1'b1;
		if (!prot[flash_pkg::PROT_HDIS]) begin
			next_prot[flash_pkg::PROT_HS_LO +: 2] = prot[flash_pkg::PROT_HS_LO +: 2];
		end
	end

	// protected byte counts before and after a write
	assign cur_prot_bytes = prot_bytes(prot);
	assign new_prot_bytes = prot_bytes(next_prot);
	assign prot_wr_ok     = (new_prot_bytes >= cur_prot_bytes);

	// protection register
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prot <= flash_pkg::PROT_RST;
		end else if (load_done) begin
			prot <= prot_byte(nv_rd_data);
		end else if (wr_prot && prot_wr_ok) begin
			prot <= next_prot;
		end
	end

	// configuration register
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			config_reg <= flash_pkg::CONFIG_RST;
		end else if (wr_config) begin
			config_reg <= bus_wdata & (8'h01 << flash_pkg::CFG_IGNORE);
		end
	end

	// fault events of one array read
	assign collision      = rd_evt.strobe && rd_evt.block_busy;
	assign genuine_double = rd_evt.strobe && rd_evt.double_err;
	assign genuine_single = rd_evt.strobe && rd_evt.single_err
		&& !config_reg[flash_pkg::CFG_IGNORE];
	assign single_clr     = wr_error && bus_wdata[flash_pkg::ERR_SINGLE];
	assign double_clr     = wr_error && bus_wdata[flash_pkg::ERR_DOUBLE];

	// fault set terms, collision first so a genuine fault sets one flag only
	always_comb begin
		set_single = 1'b0;
		set_double = 1'b0;
		if (collision) begin
			set_single = 1'b1;
			set_double = 1'b1;
		end else if (genuine_double) begin
			set_double = 1'b1;
		end else if (genuine_single) begin
			set_single = 1'b1;
		end
	end

	// single fault flag, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			single_fault_flag <= 1'b0;
		end else if (set_single) begin
			single_fault_flag <= 1'b1;
		end else if (single_clr) begin
			single_fault_flag <= 1'b0;
		end
	end

	// double fault flag, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			double_fault_flag <= 1'b0;
		end else if (set_double) begin
			double_fault_flag <= 1'b1;
		end else if (double_clr) begin
			double_fault_flag <= 1'b0;
		end
	end

	// corrected read data
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rd_data       <= 8'h00;
			rd_data_valid <= 1'b0;
		end else begin
			rd_data_valid <= rd_evt.strobe;
			if (rd_evt.strobe) begin
				if (rd_evt.single_err && !rd_evt.double_err) begin
					rd_data <= rd_evt.raw_data ^ rd_evt.flip_mask;
				end else begin
					rd_data <= rd_evt.raw_data;
				end
			end
		end
	end

	// command target checks
	assign target_protected = addr_protected(prot, cmd.addr);
	assign erase_blocked    = (cur_prot_bytes != 17'h00000);

	// command check
	always_comb begin
		cmd_blocked = protection_violation_flag || (state != flash_pkg::ST_READY);
		if (cmd.block_erase) begin
			cmd_blocked = cmd_blocked || erase_blocked;
		end else begin
			cmd_blocked = cmd_blocked || target_protected;
		end
	end

	assign cmd_accept = cmd.valid && !cmd_blocked;

	// refusal pulse
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmd_refused <= 1'b0;
		end else begin
			cmd_refused <= cmd.valid && cmd_blocked;
		end
	end

	// violation raised by a refusal once loaded, cleared by writing 1
	assign violation_set = cmd.valid && cmd_blocked && !protection_violation_flag
		&& (state == flash_pkg::ST_READY);
	assign violation_clr = wr_status && bus_wdata[flash_pkg::STAT_VIOL];

	// protection violation flag, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			protection_violation_flag <= 1'b0;
		end else if (violation_set) begin
			protection_violation_flag <= 1'b1;
		end else if (violation_clr) begin
			protection_violation_flag <= 1'b0;
		end
	end

	// read data select
	always_comb begin
		next_rdata = 8'h00;
		if (bus_rd) begin
			case (bus_addr)
				flash_pkg::OFF_CONFIG: begin
					next_rdata = config_reg;
				end
				flash_pkg::OFF_STATUS: begin
					next_rdata = status_byte(protection_violation_flag, ctrl_busy);
				end
				flash_pkg::OFF_ERROR: begin
					next_rdata = error_byte(double_fault_flag, single_fault_flag);
				end
				flash_pkg::OFF_PROT: begin
					next_rdata = prot_byte(prot);
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data, one cycle after strobe, zero otherwise
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bus_rdata <= 8'h00;
		end else begin
			bus_rdata <= next_rdata;
		end
	end

endmodule

`default_nettype wire

/* File: core/flash_pkg.sv */
`default_nettype none
package flash_pkg;

	// register offsets
	localparam logic [3:0] OFF_CONFIG = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h6;
	localparam logic [3:0] OFF_ERROR  = 4'h7;
	localparam logic [3:0] OFF_PROT   = 4'h8;

	// field positions
	localparam int CFG_IGNORE  = 0;
	localparam int STAT_VIOL   = 4;
	localparam int STAT_BUSY   = 3;
	localparam int ERR_SINGLE  = 0;
	localparam int ERR_DOUBLE  = 1;
	localparam int PROT_OPEN   = 7;
	localparam int PROT_RSVD   = 6;
	localparam int PROT_HDIS   = 5;
	localparam int PROT_HS_LO  = 3;
	localparam int PROT_LDIS   = 2;
	localparam int PROT_LS_LO  = 0;

	// reset values and error status mask
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] PROT_RST   = 8'hff;
	localparam logic [7:0] ERROR_MASK = 8'h03;

	// flash map
	localparam logic [15:0] NV_PROT_ADDR = 16'hff7c;
	localparam logic [15:0] FLASH_BASE   = 16'hc000;
	localparam logic [16:0] FLASH_TOP    = 17'h0ffff;
	localparam logic [16:0] FLASH_BYTES  = 17'h04000;
	localparam logic [16:0] SIZE_UNIT    = 17'h00400;

	typedef struct packed {
		logic       strobe;
		logic       single_err;
		logic       double_err;
		logic       block_busy;
		logic [7:0] raw_data;
		logic [7:0] flip_mask;
	} rd_evt_t;

	typedef struct packed {
		logic        valid;
		logic        block_erase;
		logic [15:0] addr;
	} cmd_t;

	typedef enum logic [1:0] {
		ST_LOAD  = 2'b01,
		ST_READY = 2'b10
	} load_st_t;

endpackage
`default_nettype wire

/* File: verif/flash_fault_protect_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_fault_protect_chk (
	// clock and reset
	input wire logic                sys_clk,
	input wire logic                nrst,
	// register port
	input wire logic [3:0]          bus_addr,
	input wire logic                bus_rd,
	input wire logic [7:0]          bus_rdata,
	// nonvolatile fetch
	input wire logic                nv_rd_req,
	input wire logic [15:0]         nv_rd_addr,
	input wire logic                nv_rd_done,
	// array reads
	input wire flash_pkg::rd_evt_t  rd_evt,
	input wire logic [7:0]          rd_data,
	input wire logic                rd_data_valid,
	// commands
	input wire flash_pkg::cmd_t     cmd,
	input wire logic                cmd_accept,
	input wire logic                cmd_refused,
	input wire logic                prot_ready
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
		else $error("read data not idle");
	a_err_rsvd: assert property (bus_rd && bus_addr == 4'h7 |=> bus_rdata[7:2] == 6'h00)
		else $error("error reserved bits set");
	a_prot_rsvd: assert property (bus_rd && bus_addr == 4'h8 |=> bus_rdata[6])
		else $error("protection reserved bit low");
	a_valid_pulse: assert property (rd_evt.strobe |=> rd_data_valid)
		else $error("read valid missing");
	a_valid_only: assert property (!rd_evt.strobe |=> !rd_data_valid)
		else $error("read valid spurious");
	a_data_fixed: assert property (rd_evt.strobe && rd_evt.single_err && !rd_evt.double_err
		&& !rd_evt.block_busy |=> rd_data == ($past(rd_evt.raw_data) ^ $past(rd_evt.flip_mask)))
		else $error("data not corrected");
	a_nv_addr: assert property (nv_rd_req |-> nv_rd_addr == 16'hff7c)
		else $error("wrong protection byte address");
	a_load_done: assert property (nv_rd_req && nv_rd_done |=> prot_ready && !nv_rd_req)
		else $error("protection load not finished");
	a_refuse_pulse: assert property (cmd.valid && !cmd_accept |=> cmd_refused)
		else $error("refusal not reported");
	a_not_ready: assert property (!prot_ready |-> !cmd_accept)
		else $error("command taken before load");
endmodule
bind flash_fault_protect flash_fault_protect_chk u_chk (.*);
`default_nettype wire

/* File: verif/nv_byte_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nv_byte_model #(
	parameter logic [7:0] NV_BYTE = 8'hbf,
	parameter int         DELAY   = 4
) (
	input  wire logic        sys_clk,
	input  wire logic        nv_rd_req,
	input  wire logic [15:0] nv_rd_addr,
	output logic             nv_rd_done,
	output logic [7:0]       nv_rd_data
);
	int cnt = 0;
	initial begin
		nv_rd_done = 1'b0;
		nv_rd_data = 8'h00;
	end
	// byte handed over after a wait; data toggles when not valid
	always @(posedge sys_clk) begin
		if (nv_rd_req && cnt == DELAY) begin
			nv_rd_done <= 1'b1;
			nv_rd_data <= (nv_rd_addr == 16'hff7c) ? NV_BYTE : 8'h00;
			cnt <= 0;
		end else begin
			nv_rd_done <= 1'b0;
			nv_rd_data <= ~nv_rd_data;
			cnt <= nv_rd_req ? cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb_flash_fault_protect.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_fault_protect;
	logic               sys_clk = 0;
	logic               nrst = 0;
	logic               bus_wr = 0;
	logic               bus_rd = 0;
	logic               ctrl_busy = 0;
	logic [3:0]         bus_addr = 4'h0;
	logic [7:0]         bus_wdata = 8'h00;
	logic [7:0]         bus_rdata;
	logic [7:0]         rd_data;
	logic [7:0]         nv_rd_data;
	logic [15:0]        nv_rd_addr;
	logic               nv_rd_req, nv_rd_done, rd_data_valid;
	logic               cmd_accept, cmd_refused, prot_ready;
	flash_pkg::rd_evt_t rd_evt = '0;
	flash_pkg::cmd_t    cmd = '0;
	int                 mismatches = 0;
	int                 tests_run = 0;
	int                 cycles = 0;
	always #20 sys_clk = ~sys_clk;
	flash_fault_protect DUT (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr), .nv_rd_done(nv_rd_done),
		.nv_rd_data(nv_rd_data), .rd_evt(rd_evt), .rd_data(rd_data),
		.rd_data_valid(rd_data_valid), .cmd(cmd), .ctrl_busy(ctrl_busy),
		.cmd_accept(cmd_accept), .cmd_refused(cmd_refused), .prot_ready(prot_ready));
	nv_byte_model u_nv (.sys_clk(sys_clk), .nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr),
		.nv_rd_done(nv_rd_done), .nv_rd_data(nv_rd_data));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 chk("reg", e, bus_rdata);
	endtask
	task arr(input logic s, d, b, input logic [7:0] fm, ef);
		@(posedge sys_clk);
		rd_evt <= '{1'b1, s, d, b, 8'h55, fm};
		@(posedge sys_clk);
		rd_evt.strobe <= 1'b0;
		#1 chk("valid", 8'h01, {7'h00, rd_data_valid});
		chk("data", 8'h55 ^ fm, rd_data);
		rd(4'h7, ef);
	endtask
	task cm(input logic be, input logic [15:0] a, input logic acc);
		@(posedge sys_clk);
		cmd <= '{1'b1, be, a};
		#1 chk("accept", {7'h00, acc}, {7'h00, cmd_accept});
		@(posedge sys_clk);
		cmd.valid <= 1'b0;
		#1 chk("refused", {7'h00, !acc}, {7'h00, cmd_refused});
	endtask
	task end_sim;
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		while (!prot_ready && cycles < 100) @(posedge sys_clk);
		chk("ready", 8'h01, {7'h00, prot_ready});
		rd(4'h8, 8'hff);
		cm(1'b0, 16'hf000, 1'b1);
		wr(4'h8, 8'hdf);
		rd(4'h8, 8'hdf);
		cm(1'b0, 16'hf000, 1'b0);
		rd(4'h6, 8'h10);
		cm(1'b0, 16'hc000, 1'b0);
		wr(4'h6, 8'h10);
		rd(4'h6, 8'h00);
		cm(1'b0, 16'hc000, 1'b1);
		cm(1'b1, 16'hc000, 1'b0);
		wr(4'h6, 8'h10);
		wr(4'h8, 8'hff);
		rd(4'h8, 8'hdf);
		wr(4'h8, 8'h5f);
		rd(4'h8, 8'h5f);
		cm(1'b0, 16'hf000, 1'b1);
		cm(1'b0, 16'hff7c, 1'b1);
		cm(1'b0, 16'hc000, 1'b0);
		wr(4'h6, 8'h10);
		wr(4'h8, 8'h47);
		rd(4'h8, 8'h5f);
		wr(4'h4, 8'h00);
		arr(1'b1, 1'b0, 1'b0, 8'h01, 8'h01);
		wr(4'h7, 8'hfc);
		rd(4'h7, 8'h01);
		wr(4'h7, 8'hff);
		rd(4'h7, 8'h00);
		arr(1'b1, 1'b1, 1'b0, 8'h00, 8'h02);
		wr(4'h7, 8'h01);
		rd(4'h7, 8'h02);
		wr(4'h7, 8'h02);
		rd(4'h7, 8'h00);
		arr(1'b0, 1'b0, 1'b1, 8'h00, 8'h03);
		wr(4'h7, 8'h03);
		wr(4'h4, 8'h01);
		rd(4'h4, 8'h01);
		arr(1'b1, 1'b0, 1'b0, 8'h80, 8'h00);
		@(posedge sys_clk);
		ctrl_busy <= 1'b1;
		rd(4'h6, 8'h08);
		rd(4'hf, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
